//--- core/sync_serial_regs.vh
// register map, field positions and reset values of the serial status block
`ifndef SYNC_SERIAL_REGS_VH
`define SYNC_SERIAL_REGS_VH
`define ADDR_W 4
`define OFF_STATUS 4'h0
`define OFF_CONTROL 4'h1
`define OFF_TXDATA 4'h2
`define OFF_RXDATA 4'h3
`define OFF_IRQ_STAT 4'h4
`define OFF_IRQ_EN 4'h5
`define OFF_IRQ_CLR 4'h6
`define OFF_TIMING 4'h7
`define BIT_OVR 6
`define BIT_TXDONE 3
`define BIT_TXEMPTY 2
`define BIT_RXFULL 1
`define BIT_TXEN 7
`define BIT_RXEN 6
`define STATUS_RST 8'h0c
`define CTRL_RST 8'h00
`define NUM_IRQ 4
`define IRQ_OVR 3
`define IRQ_TXDONE 2
`define IRQ_TXEMPTY 1
`define IRQ_RXFULL 0
`define DONE_DELAY_DEF 8'h04
`endif

//--- core/sync_edge_detect.v
// two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module sync_edge_detect #(
  parameter IDLE_LVL = 1'b0
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // asynchronous level in
  input wire async_in,
  // synchronised level and edges
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_r;
  reg sync_r;
  reg prev_r;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= IDLE_LVL;
      sync_r <= IDLE_LVL;
      prev_r <= IDLE_LVL;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule // sync_edge_detect

//--- core/sync_serial_status_flags.v
// status flags, transmit and receive holding registers of a synchronous serial unit
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "sync_serial_regs.vh"

module sync_serial_status_flags #(
  parameter DATA_W = 8,
  parameter DONE_DELAY = `DONE_DELAY_DEF
) (
  // system
  input wire core_clk,
  input wire rst,
  // register port
  input wire [`ADDR_W-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  output reg [7:0] regRdData,
  // serial link
  input wire linkClk,
  input wire linkRxd,
  output reg linkTxd,
  // shift engine status
  output wire engineStall,
  // interrupt
  output wire irq
);
  ////////////////////////////////////////////////////////////////////////////
  localparam CNT_W = 6;
  localparam [CNT_W-1:0] LAST_BIT = DATA_W - 1;
  // a transmit frame ends at the fall that launches its final bit, since the
  // far side may park its clock right after that bit
  localparam [CNT_W-1:0] PRE_LAST = DATA_W - 2;
  localparam [7:0] STATUS_INIT = `STATUS_RST;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SHIFT = 3'h2;
  localparam [2:0] ST_TAIL = 3'h4;

  wire clkRise;
  wire clkFall;
  wire rxdLevel;

  // both link lines idle high; a low reset value would fake an edge after reset
  sync_edge_detect #(.IDLE_LVL(1'b1)) uClk (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(linkClk),
    .level(),
    .rise(clkRise),
    .fall(clkFall)
  );

  sync_edge_detect #(.IDLE_LVL(1'b1)) uRxd (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(linkRxd),
    .level(rxdLevel),
    .rise(),
    .fall()
  );

  ////////////////////////////////////////////////////////////////////////////
  reg overrunFlag_r;
  reg txDoneFlag_r;
  reg txEmptyFlag_r;
  reg rxFullFlag_r;
  reg [7:0] control_r;
  reg timingSel_r;
  reg [DATA_W-1:0] txHolding_r;
  reg [DATA_W-1:0] rxHolding_r;
  reg [DATA_W-1:0] txShift_r;
  reg [DATA_W-1:0] rxShift_r;
  reg [CNT_W-1:0] txCnt_r;
  reg [CNT_W-1:0] rxCnt_r;
  reg [7:0] tailCnt_r;
  reg [2:0] txState_r;
  reg [2:0] txState_nxt;
  // remembers which flags were last read as one, so a zero write may clear
  reg [7:0] seenOne_r;
  reg [`NUM_IRQ-1:0] irqStat_r;
  reg [`NUM_IRQ-1:0] irqEn_r;

  wire txEnable = control_r[`BIT_TXEN];
  wire rxEnable = control_r[`BIT_RXEN];
  wire wrStatus = regWrStb && (regAddr == `OFF_STATUS);
  wire rdStatus = regRdStb && (regAddr == `OFF_STATUS);
  wire wrTxData = regWrStb && (regAddr == `OFF_TXDATA);
  wire rdRxData = regRdStb && (regAddr == `OFF_RXDATA);
  wire [7:0] statusView;

  assign statusView = {1'b0, overrunFlag_r, 2'b00, txDoneFlag_r, txEmptyFlag_r,
    rxFullFlag_r, 1'b0};

  assign engineStall = overrunFlag_r;

  ////////////////////////////////////////////////////////////////////////////
  // receive engine: samples on rising link clock edges
  wire rxSample = clkRise && rxEnable && !overrunFlag_r;
  wire rxDoneEv = rxSample && (rxCnt_r == LAST_BIT);
  wire overrunEv = rxDoneEv && rxFullFlag_r;
  wire rxLoadEv = rxDoneEv && !rxFullFlag_r;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rxShift_r <= {DATA_W{1'b0}};
      rxCnt_r <= {CNT_W{1'b0}};
      rxHolding_r <= {DATA_W{1'b0}};
    end
    else
    begin
      if (!rxEnable)
        rxCnt_r <= {CNT_W{1'b0}};
      else if (rxSample)
      begin
        rxShift_r <= {rxShift_r[DATA_W-2:0], rxdLevel};
        rxCnt_r <= (rxCnt_r == LAST_BIT) ? {CNT_W{1'b0}} : rxCnt_r + 1'b1;
      end
      // only a free holding register takes a frame
      if (rxLoadEv)
        rxHolding_r <= {rxShift_r[DATA_W-2:0], rxdLevel};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit engine: shifts on falling link clock edges
  wire txGo = clkFall && !overrunFlag_r;
  // a new frame starts only from idle or tail, on a falling link edge
  wire loadShift = (txState_r != ST_SHIFT) && txGo && txEnable && !txEmptyFlag_r;
  wire lastBitEv = (txState_r == ST_SHIFT) && txGo && (txCnt_r == PRE_LAST);
  // timing one waits DONE_DELAY+1 core cycles after the last-bit fall; keep it below half a link period
  wire tailDone = (txState_r == ST_TAIL) && (tailCnt_r == DONE_DELAY);

  always @*
  begin
    txState_nxt = txState_r;
    case (txState_r)
      ST_IDLE:
        if (loadShift)
          txState_nxt = ST_SHIFT;
      ST_SHIFT:
        if (lastBitEv)
          txState_nxt = timingSel_r ? ST_TAIL : ST_IDLE;
      ST_TAIL:
        if (loadShift)
          txState_nxt = ST_SHIFT;
        else if (tailDone)
          txState_nxt = ST_IDLE;
      default:
        txState_nxt = ST_IDLE;
    endcase
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      txState_r <= ST_IDLE;
      txShift_r <= {DATA_W{1'b0}};
      txCnt_r <= {CNT_W{1'b0}};
      tailCnt_r <= 8'h00;
      linkTxd <= 1'b1;
    end
    else
    begin
      txState_r <= txState_nxt;
      tailCnt_r <= (txState_r == ST_TAIL) ? tailCnt_r + 8'h01 : 8'h00;
      if (loadShift)
      begin
        txShift_r <= {txHolding_r[DATA_W-2:0], 1'b0};
        linkTxd <= txHolding_r[DATA_W-1];
        txCnt_r <= {CNT_W{1'b0}};
      end
      else if (txState_r == ST_SHIFT && txGo)
      begin
        txShift_r <= {txShift_r[DATA_W-2:0], 1'b0};
        linkTxd <= txShift_r[DATA_W-1];
        txCnt_r <= txCnt_r + 1'b1;
      end
    end
  end

  // done moment depends on timing select
  wire txDoneEv = txEmptyFlag_r && !loadShift &&
    ((lastBitEv && !timingSel_r) || tailDone);

  ////////////////////////////////////////////////////////////////////////////
  // status flags: hardware set wins over software clear
  wire zeroWr = wrStatus;
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      overrunFlag_r <= STATUS_INIT[`BIT_OVR];
      txDoneFlag_r <= STATUS_INIT[`BIT_TXDONE];
      txEmptyFlag_r <= STATUS_INIT[`BIT_TXEMPTY];
      rxFullFlag_r <= STATUS_INIT[`BIT_RXFULL];
      seenOne_r <= 8'h00;
      txHolding_r <= {DATA_W{1'b0}};
    end
    else
    begin
      if (rdStatus)
        seenOne_r <= statusView;
      else if (wrStatus)
        seenOne_r <= 8'h00;
      if (wrTxData)
        txHolding_r <= regWrData[DATA_W-1:0];
      if (overrunEv)
        overrunFlag_r <= 1'b1;
      else if (zeroWr && !regWrData[`BIT_OVR] && seenOne_r[`BIT_OVR])
        overrunFlag_r <= 1'b0;
      if (txDoneEv)
        txDoneFlag_r <= 1'b1;
      else if (wrTxData)
        txDoneFlag_r <= 1'b0;
      else if (zeroWr && !regWrData[`BIT_TXDONE] && seenOne_r[`BIT_TXDONE])
        txDoneFlag_r <= 1'b0;
      if (!txEnable || loadShift)
        txEmptyFlag_r <= 1'b1;
      else if (wrTxData)
        txEmptyFlag_r <= 1'b0;
      else if (zeroWr && !regWrData[`BIT_TXEMPTY] && seenOne_r[`BIT_TXEMPTY])
        txEmptyFlag_r <= 1'b0;
      if (rxLoadEv)
        rxFullFlag_r <= 1'b1;
      else if (rdRxData)
        rxFullFlag_r <= 1'b0;
      else if (zeroWr && !regWrData[`BIT_RXFULL] && seenOne_r[`BIT_RXFULL])
        rxFullFlag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, interrupt and read port
  wire [`NUM_IRQ-1:0] irqEv = {overrunEv, txDoneEv, loadShift, rxLoadEv};
  wire wrIrqClr = regWrStb && (regAddr == `OFF_IRQ_CLR);

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      control_r <= `CTRL_RST;
      timingSel_r <= 1'b0;
      irqEn_r <= {`NUM_IRQ{1'b0}};
      irqStat_r <= {`NUM_IRQ{1'b0}};
      regRdData <= 8'h00;
    end
    else
    begin
      // only the enable bits are kept; the rest read zero
      if (regWrStb && regAddr == `OFF_CONTROL)
      begin
        control_r[`BIT_TXEN] <= regWrData[`BIT_TXEN];
        control_r[`BIT_RXEN] <= regWrData[`BIT_RXEN];
      end
      if (regWrStb && regAddr == `OFF_TIMING)
        timingSel_r <= regWrData[0];
      if (regWrStb && regAddr == `OFF_IRQ_EN)
        irqEn_r <= regWrData[`NUM_IRQ-1:0];
      irqStat_r <= irqEv | (irqStat_r & ~(wrIrqClr ? regWrData[`NUM_IRQ-1:0] :
        {`NUM_IRQ{1'b0}}));
      regRdData <= 8'h00;
      if (regRdStb)
        case (regAddr)
          `OFF_STATUS: regRdData <= statusView;
          `OFF_CONTROL: regRdData <= control_r;
          `OFF_TXDATA: regRdData <= txHolding_r;
          `OFF_RXDATA: regRdData <= rxHolding_r;
          `OFF_IRQ_STAT: regRdData <= {4'h0, irqStat_r};
          `OFF_IRQ_EN: regRdData <= {4'h0, irqEn_r};
          `OFF_TIMING: regRdData <= {7'h00, timingSel_r};
          default: regRdData <= 8'h00;
        endcase
    end
  end

  assign irq = |(irqStat_r & irqEn_r);
endmodule // sync_serial_status_flags

//--- tb/sync_serial_status_flags_asserts.sv
// port assertions of the serial status flag block
`timescale 1ns/1ps
`include "sync_serial_regs.vh"
module sync_serial_status_flags_asserts #(
  parameter DATA_W = 8,
  parameter DONE_DELAY = 4
) (
  // system and register port
  input wire core_clk,
  input wire rst,
  input wire [`ADDR_W-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  input wire [7:0] regRdData,
  // link, engine and interrupt
  input wire linkClk,
  input wire linkRxd,
  input wire linkTxd,
  input wire engineStall,
  input wire irq
);
  reg txEn_r;
  wire stRd = regRdStb && regAddr == `OFF_STATUS;
  wire stWr = regWrStb && regAddr == `OFF_STATUS && !regWrData[`BIT_OVR];
  wire enOff = regWrStb && regAddr == `OFF_IRQ_EN && regWrData == 8'h00;
  // shadow of the transmit enable bit
  always @(posedge core_clk or posedge rst)
    if (rst)
      txEn_r <= 1'b0;
    else if (regWrStb && regAddr == `OFF_CONTROL)
      txEn_r <= regWrData[`BIT_TXEN];
  ////////////////////////////////////////
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  chk_rd_idle: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
    else $error("read data not zero outside read");
  chk_rsv_zero: assert property (
    $past(stRd) |-> (regRdData & 8'hb1) == 8'h00)
    else $error("reserved status bit set");
  chk_stall_flag: assert property (
    $past(stRd) |-> regRdData[6] == $past(engineStall))
    else $error("overrun flag and stall differ");
  chk_stall_txd: assert property (
    engineStall && $past(engineStall) |-> $stable(linkTxd))
    else $error("transmit shifts while stalled");
  chk_ovr_clear: assert property (
    $fell(engineStall) |-> $past(stWr))
    else $error("overrun cleared without zero write");
  chk_irq_mask: assert property ($past(enOff) |-> !irq)
    else $error("interrupt high with all masked");
  chk_txe_dis: assert property (
    $past(stRd) && !$past(txEn_r, 2) |-> regRdData[2])
    else $error("tx empty low while tx disabled");
  chk_txd_fall: assert property (
    $changed(linkTxd) |-> !$past(linkClk))
    else $error("transmit data moved off falling clock");
  cover property ($rose(engineStall));
  cover property ($rose(irq));
  cover property ($past(stRd) && regRdData[3]);
endmodule // sync_serial_status_flags_asserts
bind sync_serial_status_flags sync_serial_status_flags_asserts #(
  .DATA_W(DATA_W), .DONE_DELAY(DONE_DELAY)) chk_u (
  .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
  .linkClk(linkClk), .linkRxd(linkRxd), .linkTxd(linkTxd),
  .engineStall(engineStall), .irq(irq));

//--- tb/serial_peer.sv
// far-end serial peer clocking frames in and out
`timescale 1ns/1ps
module serial_peer (
  // link
  output reg linkClk,
  output reg linkRxd,
  input wire linkTxd
);
  reg [7:0] txCap;
  initial
  begin
    linkClk = 1'b1;
    linkRxd = 1'b1;
    txCap = 8'h00;
  end
  // clock idles high between frames, msb first
  task frame(input [7:0] d);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        linkClk = 1'b0;
        linkRxd = d[i];
        #62.5;
        linkClk = 1'b1;
        txCap = {txCap[6:0], linkTxd};
        #62.5;
      end
      // released line must not keep a stale bit
      linkRxd = ~d[0];
    end
  endtask
endmodule // serial_peer

//--- tb/tb_sync_serial_status_flags.sv
// self-checking bench of the serial status flag block
`timescale 1ns/1ps
module tb_sync_serial_status_flags;
  reg core_clk, rst, regWrStb, regRdStb;
  reg [3:0] regAddr;
  reg [7:0] regWrData, d, r1, r2, v;
  reg [31:0] seed;
  wire [7:0] regRdData;
  wire linkClk, linkRxd, linkTxd, engineStall, irq;
  integer n_fail, tests_run;
  sync_serial_status_flags dut_u (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .linkClk(linkClk), .linkRxd(linkRxd), .linkTxd(linkTxd),
    .engineStall(engineStall), .irq(irq));
  serial_peer peer (.linkClk(linkClk), .linkRxd(linkRxd), .linkTxd(linkTxd));
  ////////////////////////////////////////
  function [7:0] stat(input o, input dn, input e, input f);
    stat = {1'b0, o, 2'b00, dn, e, f, 1'b0};
  endfunction
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task rnd;
    begin
      seed = xs(seed);
    end
  endtask
  task chk(input [63:0] nm, input [7:0] s, input [7:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e)
      begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] dt);
    begin
      @(posedge core_clk);
      regWrStb <= 1'b1;
      regAddr <= a;
      regWrData <= dt;
      @(posedge core_clk);
      regWrStb <= 1'b0;
      #1;
    end
  endtask
  task rd(input [3:0] a, output [7:0] dt);
    begin
      @(posedge core_clk);
      regRdStb <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRdStb <= 1'b0;
      #1;
      dt = regRdData;
    end
  endtask
  // link clock starts 3 ns after a core rising edge
  task fr(input [7:0] b);
    begin
      @(posedge core_clk);
      #3;
      peer.frame(b);
      repeat (12) @(posedge core_clk);
    end
  endtask
  task complete_run;
    begin
      if (n_fail == 0 && tests_run > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial
  begin
    #50000;
    n_fail = n_fail + 1;
    complete_run;
  end
  initial
  begin
    rst = 1'b1;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    regAddr = 4'h0;
    regWrData = 8'h00;
    seed = 32'd19979;
    n_fail = 0;
    tests_run = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h0, v);
    chk("status", v, stat(0, 1, 1, 0));
    wr(4'h0, 8'hff);
    wr(4'h0, 8'h00);
    rd(4'h0, v);
    chk("status", v, stat(0, 1, 1, 0));
    wr(4'h0, 8'h00);
    rd(4'h0, v);
    chk("status", v, stat(0, 0, 1, 0));
    wr(4'h1, 8'hc0);
    rnd;
    d = seed[7:0];
    wr(4'h2, d);
    rd(4'h0, v);
    chk("status", v, stat(0, 0, 0, 0));
    rnd;
    r1 = seed[7:0];
    fr(r1);
    chk("txbyte", peer.txCap, d);
    rd(4'h0, v);
    chk("status", v, stat(0, 1, 1, 1));
    rd(4'h4, v);
    chk("irqstat", v, 8'h07);
    wr(4'h5, 8'h04);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(4'h6, 8'h04);
    chk("irq", {7'h00, irq}, 8'h00);
    rd(4'h4, v);
    chk("irqstat", v, 8'h03);
    wr(4'h5, 8'h00);
    rd(4'h9, v);
    chk("unmapped", v, 8'h00);
    rnd;
    r2 = seed[7:0];
    fr(r2);
    rd(4'h0, v);
    chk("status", v, stat(1, 1, 1, 1));
    chk("stall", {7'h00, engineStall}, 8'h01);
    rd(4'h3, v);
    chk("rxdata", v, r1);
    rnd;
    d = seed[7:0];
    wr(4'h2, d);
    fr(r2);
    wr(4'h0, 8'hff);
    wr(4'h0, 8'h00);
    rd(4'h0, v);
    chk("status", v, stat(1, 0, 0, 0));
    wr(4'h0, 8'hbf);
    rd(4'h0, v);
    chk("status", v, stat(0, 0, 0, 0));
    chk("stall", {7'h00, engineStall}, 8'h00);
    wr(4'h7, 8'h01);
    fr(r2);
    chk("txbyte", peer.txCap, d);
    rd(4'h0, v);
    chk("status", v, stat(0, 1, 1, 1));
    wr(4'h0, 8'hf1);
    rd(4'h0, v);
    chk("status", v, stat(0, 0, 0, 0));
    wr(4'h1, 8'h00);
    rnd;
    d = seed[7:0];
    wr(4'h2, d);
    rd(4'h0, v);
    chk("status", v, stat(0, 0, 1, 0));
    complete_run;
  end
endmodule // tb_sync_serial_status_flags
